// >>> verilog/hbrsc_pkg.sv
// package: constants and types for host bus reset and suspend control
package hbrsc_pkg;

    // =========================================================
    // storage geometry
    // =========================================================
    localparam int unsigned BUS_W        = 32;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned IDX_W        = 3;
    localparam int unsigned REG_COUNT    = 8;
    // indices below this hold wake-event context (kept over bus reset)
    localparam int unsigned STICKY_COUNT = 2;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [DATA_W-1:0] REG_RESET_VAL  = 8'h00;
    localparam logic [BUS_W-1:0]  BUS_RESET_VAL  = 32'h0000_0000;

    // =========================================================
    // reset cause encoding
    // =========================================================
    localparam logic [1:0] CAUSE_NONE   = 2'h0;
    localparam logic [1:0] CAUSE_GLOBAL = 2'h1;
    localparam logic [1:0] CAUSE_HOST   = 2'h2;
    localparam logic [1:0] CAUSE_HELD   = 2'h3;

    // =========================================================
    // operating state, one-hot
    // =========================================================
    typedef enum logic [1:0] {
        ST_RESET = 2'b01,
        ST_RUN   = 2'b10
    } hbrsc_state_t;

endpackage

// >>> verilog/hbrsc_rstq.sv
// module: registered decode of the reset and hold inputs
module hbrsc_rstq
    import hbrsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic global_reset_n,
    input  wire logic host_bus_reset_n,
    input  wire logic reg_hold_n,
    output logic      clr_all,
    output logic      clr_func,
    output logic      any_rst,
    output logic      held
);

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic clr_all;
        logic clr_func;
        logic any_rst;
        logic held;
    } hbrsc_rstq_st_t;

    hbrsc_rstq_st_t st_reg;
    hbrsc_rstq_st_t st_next;

    // active-low pin to asserted level
    function automatic logic is_asserted(input logic pin_n);
        is_asserted = ~pin_n;
    endfunction

    // decode, sampled on the rising clock edge
    always_comb
    begin
        st_next          = st_reg;
        st_next.any_rst  = is_asserted(global_reset_n)
                         | is_asserted(host_bus_reset_n);
        // hold blocks every clearing, global or bus
        st_next.clr_all  = is_asserted(global_reset_n)
                         & ~is_asserted(reg_hold_n);
        st_next.clr_func = is_asserted(host_bus_reset_n)
                         & ~is_asserted(reg_hold_n);
        st_next.held     = st_next.any_rst
                         & is_asserted(reg_hold_n);
    end

    // registers; any_rst starts asserted, the other outputs low, until the first decode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '{clr_all: 1'b0, clr_func: 1'b0,
                        any_rst: 1'b1, held: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign clr_all  = st_reg.clr_all;
    assign clr_func = st_reg.clr_func;
    assign any_rst  = st_reg.any_rst;
    assign held     = st_reg.held;

endmodule

// >>> verilog/hbrsc_top.sv
// module: host bus reset, clocking and suspend control with register store
//
// Contract
// - Global reset floats all outputs and clears every internal register.
// - Host bus reset floats all outputs and clears only the function group.
// - Under host bus reset nothing operates; release brings default state.
// - With hold active, global reset floats outputs but keeps registers.
// - With hold and host bus reset both active, all registers are kept.
// - All host bus inputs are sampled on the rising edge of the clock.
module hbrsc_top
    import hbrsc_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       NRST,
    input  wire logic                       GLOBAL_RESET_N,
    input  wire logic                       HOST_BUS_RESET_N,
    input  wire logic                       REG_HOLD_N,
    input  wire logic [hbrsc_pkg::BUS_W-1:0] BUS_IN,
    input  wire logic                       WR_EN,
    input  wire logic [hbrsc_pkg::IDX_W-1:0] WR_IDX,
    input  wire logic [hbrsc_pkg::DATA_W-1:0] WR_DATA,
    input  wire logic [hbrsc_pkg::IDX_W-1:0] RD_IDX,
    output logic      [hbrsc_pkg::DATA_W-1:0] RD_DATA,
    output logic      [hbrsc_pkg::BUS_W-1:0] BUS_SAMPLE,
    output logic                            BUS_OE_N,
    output logic                            FUNC_READY,
    output logic      [1:0]                 RESET_CAUSE
);

    import hbrsc_pkg::*;

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        hbrsc_state_t                         st;
        logic                                 oe_n;
        logic                                 ready;
        logic [BUS_W-1:0]                     sample;
        logic [DATA_W-1:0]                    rd;
        logic [1:0]                           cause;
        logic [REG_COUNT-1:0][DATA_W-1:0]     regs;
    } hbrsc_top_st_t;

    hbrsc_top_st_t st_reg;
    hbrsc_top_st_t st_next;

    // decoded reset controls
    logic q_clr_all;
    logic q_clr_func;
    logic q_any;
    logic q_held;
    logic run;

    // true for registers outside the wake-context group
    function automatic logic is_func_idx(input int unsigned idx);
        is_func_idx = (idx >= STICKY_COUNT);
    endfunction

    // =========================================================
    // reset qualifier
    // =========================================================
    // one stage of decode; aligns all reset pins to the clock
    hbrsc_rstq u_rstq
    (
        .clk              (CLK),
        .nrst             (NRST),
        .global_reset_n   (GLOBAL_RESET_N),
        .host_bus_reset_n (HOST_BUS_RESET_N),
        .reg_hold_n       (REG_HOLD_N),
        .clr_all          (q_clr_all),
        .clr_func         (q_clr_func),
        .any_rst          (q_any),
        .held             (q_held)
    );

    // functional only in run state with no reset pending
    // run stays low for the edge after a release as well, so the
    // first write lands one edge after ready rises; a write and a
    // decoded clear never meet, since a clear implies any reset
    assign run = (st_reg.st == ST_RUN) & ~q_any;

    // =========================================================
    // next state
    // =========================================================
    always_comb
    begin
        st_next = st_reg;

        // =====================================================
        // operating state
        // =====================================================
        // leaves run on any decoded reset, back on its release
        case (st_reg.st)
            ST_RESET:
            begin
                if (!q_any)
                begin
                    st_next.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (q_any)
                begin
                    st_next.st = ST_RESET;
                end
            end
            default:
            begin
                st_next.st = ST_RESET;
            end
        endcase

        // =====================================================
        // output buffers
        // =====================================================
        // float during any reset, hold or not; drive otherwise
        st_next.oe_n = q_any;

        // =====================================================
        // register clearing
        // =====================================================
        // global wins over bus reset; hold already masked both in
        // the qualifier, so a held reset lands in the last branch
        // and leaves every register as it was
        if (q_clr_all)
        begin
            for (int unsigned i = 0; i < REG_COUNT; i++)
            begin
                st_next.regs[i] = REG_RESET_VAL;
            end
            st_next.cause = CAUSE_GLOBAL;
        end
        else if (q_clr_func)
        begin
            for (int unsigned i = 0; i < REG_COUNT; i++)
            begin
                if (is_func_idx(i))
                begin
                    st_next.regs[i] = REG_RESET_VAL;
                end
            end
            st_next.cause = CAUSE_HOST;
        end
        else if (q_held)
        begin
            // contents kept, only the buffers float
            st_next.cause = CAUSE_HELD;
        end

        // =====================================================
        // write port
        // =====================================================
        // writes accepted only while functional; a write under
        // reset is dropped, not deferred
        if (run && WR_EN)
        begin
            st_next.regs[WR_IDX] = WR_DATA;
        end

        // =====================================================
        // read port and bus sampling
        // =====================================================
        // quiet outside run; read data is the stored word before
        // any write of the same edge
        if (run)
        begin
            st_next.rd     = st_reg.regs[RD_IDX];
            st_next.sample = BUS_IN;
        end
        else
        begin
            st_next.rd     = REG_RESET_VAL;
            st_next.sample = BUS_RESET_VAL;
        end

        // =====================================================
        // ready flag
        // =====================================================
        // ready follows the coming state, so it rises together with
        // the buffers being driven again
        st_next.ready = (st_next.st == ST_RUN) & ~q_any;
    end

    // =========================================================
    // registers
    // =========================================================
    // power-on reset: constants only; the pin resets are synchronous
    // and act through the next-state logic, never through this branch
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_reg.st     <= ST_RESET;
            st_reg.oe_n   <= 1'b1;
            st_reg.ready  <= 1'b0;
            st_reg.sample <= BUS_RESET_VAL;
            st_reg.rd     <= REG_RESET_VAL;
            st_reg.cause  <= CAUSE_NONE;
            for (int unsigned i = 0; i < REG_COUNT; i++)
            begin
                st_reg.regs[i] <= REG_RESET_VAL;
            end
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs, each straight from a flip-flop
    // =========================================================
    assign RD_DATA     = st_reg.rd;
    assign BUS_SAMPLE  = st_reg.sample;
    assign BUS_OE_N    = st_reg.oe_n;
    assign FUNC_READY  = st_reg.ready;
    assign RESET_CAUSE = st_reg.cause;

endmodule

// >>> tb/hbrsc_chk.sv
// checker: port assertions for host bus reset and suspend control
module hbrsc_chk
    import hbrsc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        GLOBAL_RESET_N,
    input wire logic        HOST_BUS_RESET_N,
    input wire logic        REG_HOLD_N,
    input wire logic [31:0] BUS_IN,
    input wire logic        WR_EN,
    input wire logic [2:0]  WR_IDX,
    input wire logic [7:0]  WR_DATA,
    input wire logic [2:0]  RD_IDX,
    input wire logic [7:0]  RD_DATA,
    input wire logic [31:0] BUS_SAMPLE,
    input wire logic        BUS_OE_N,
    input wire logic        FUNC_READY,
    input wire logic [1:0]  RESET_CAUSE
);
    timeunit 1ns;
    timeprecision 100ps;
    // both reset pins released
    logic up;
    assign up = GLOBAL_RESET_N & HOST_BUS_RESET_N;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // =====
    // assertions
    a_float_reset: assert property (!up |-> ##2 BUS_OE_N && !FUNC_READY)
        else $error("outputs not floated under reset");
    a_quiet_off: assert property (!FUNC_READY |->
        RD_DATA == 8'h00 && BUS_SAMPLE == 32'h0000_0000)
        else $error("outputs active while not functional");
    a_ready_up: assert property (up [*3] |=> FUNC_READY && !BUS_OE_N)
        else $error("not functional after release");
    a_clear_global: assert property (!GLOBAL_RESET_N && REG_HOLD_N
        |-> ##3 RESET_CAUSE == CAUSE_GLOBAL)
        else $error("global clear cause wrong");
    a_clear_host: assert property (!HOST_BUS_RESET_N && GLOBAL_RESET_N
        && REG_HOLD_N |-> ##3 RESET_CAUSE == CAUSE_HOST)
        else $error("host clear cause wrong");
    a_hold_keeps: assert property (!up && !REG_HOLD_N
        |-> ##3 RESET_CAUSE == CAUSE_HELD)
        else $error("held cause wrong");
    a_bus_sample: assert property (FUNC_READY && $past(FUNC_READY)
        |-> BUS_SAMPLE == $past(BUS_IN))
        else $error("bus sample mismatch");
    a_write_read: assert property ((FUNC_READY && WR_EN && up && $past(up))
        ##1 (FUNC_READY && RD_IDX == $past(WR_IDX))
        |=> RD_DATA == $past(WR_DATA, 2))
        else $error("read back mismatch");
    // main scenarios
    c_held: cover property (RESET_CAUSE == CAUSE_HELD);
    c_host: cover property (RESET_CAUSE == CAUSE_HOST);
    c_write: cover property (FUNC_READY && WR_EN);
endmodule

bind hbrsc_top hbrsc_chk i_chk (.CLK(CLK), .NRST(NRST),
    .GLOBAL_RESET_N(GLOBAL_RESET_N), .HOST_BUS_RESET_N(HOST_BUS_RESET_N),
    .REG_HOLD_N(REG_HOLD_N), .BUS_IN(BUS_IN), .WR_EN(WR_EN),
    .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .RD_IDX(RD_IDX), .RD_DATA(RD_DATA),
    .BUS_SAMPLE(BUS_SAMPLE), .BUS_OE_N(BUS_OE_N), .FUNC_READY(FUNC_READY),
    .RESET_CAUSE(RESET_CAUSE));

// >>> tb/hbrsc_host.sv
// model: host system that drives the global and bus reset pins
module hbrsc_host (
    input  wire logic clk,
    input  wire logic boot,
    input  wire logic rst_req,
    input  wire logic tie,
    output logic      global_reset_n = 1'b0,
    output logic      host_bus_reset_n = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    logic booted_reg = 1'b0;
    // =====
    // pins change just after the clock edge; global starts asserted
    always @(posedge clk)
    begin
        booted_reg <= booted_reg | ~boot;
        host_bus_reset_n <= ~rst_req;
        global_reset_n <= tie ? ~rst_req : ~(boot & ~booted_reg);
    end
endmodule

// >>> tb/hbrsc_tb_top.sv
// testbench: host bus reset and suspend control
module hbrsc_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hbrsc_pkg::*;
    typedef struct packed
    {int c; logic [1:0] rc; logic f; logic [7:0] d; logic [31:0] b;}
    hbrsc_note_t;
    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        REG_HOLD_N = 1'b1;
    logic        WR_EN = 1'b0;
    logic [2:0]  WR_IDX = 3'h0;
    logic [2:0]  RD_IDX = 3'h0;
    logic [7:0]  WR_DATA = 8'h00;
    logic [31:0] BUS_IN = 32'h0000_0000;
    logic        boot = 1'b1;
    logic        rst_req = 1'b0;
    logic        tie = 1'b0;
    logic        fn = 1'b0;
    logic [1:0]  cause = CAUSE_NONE;
    logic [7:0]  m [8] = '{default: 8'h00};
    wire         GLOBAL_RESET_N, HOST_BUS_RESET_N, BUS_OE_N, FUNC_READY;
    wire  [7:0]  RD_DATA;
    wire  [31:0] BUS_SAMPLE;
    wire  [1:0]  RESET_CAUSE;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    integer      seed = 32'h2b87;
    hbrsc_note_t q [$];
    hbrsc_note_t nt;
    // =====
    // clock and cycle count
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) cyc <= cyc + 1;
    hbrsc_host i_host (.clk(CLK), .boot(boot), .rst_req(rst_req), .tie(tie),
        .global_reset_n(GLOBAL_RESET_N), .host_bus_reset_n(HOST_BUS_RESET_N));
    hbrsc_top i_dut (.CLK(CLK), .NRST(NRST), .GLOBAL_RESET_N(GLOBAL_RESET_N),
        .HOST_BUS_RESET_N(HOST_BUS_RESET_N), .REG_HOLD_N(REG_HOLD_N),
        .BUS_IN(BUS_IN), .WR_EN(WR_EN), .WR_IDX(WR_IDX), .WR_DATA(WR_DATA),
        .RD_IDX(RD_IDX), .RD_DATA(RD_DATA), .BUS_SAMPLE(BUS_SAMPLE),
        .BUS_OE_N(BUS_OE_N), .FUNC_READY(FUNC_READY),
        .RESET_CAUSE(RESET_CAUSE));
    // one cycle of stimulus; notes what shows two edges later
    task step(input logic we, input logic [2:0] wi, input logic [2:0] ri);
        logic [7:0]  d;
        logic [31:0] b;
        @(posedge CLK);
        d = 8'($random(seed));
        b = $random(seed);
        WR_EN <= we;
        WR_IDX <= wi;
        WR_DATA <= d;
        BUS_IN <= b;
        RD_IDX <= ri;
        q.push_back('{cyc + 2, cause, fn, fn ? m[ri] : 8'h00, fn ? b : 32'h0});
        if (fn && we)
            m[wi] = d;
    endtask
    task complete_run;
        if (q.size() != 0)
            n_fail++;
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // =====
    // compare oldest note with outputs, settled at the falling edge
    always @(negedge CLK)
    begin
        if (q.size() > 0 && q[0].c == cyc)
        begin
            nt = q.pop_front();
            checked++;
            if ({RESET_CAUSE, FUNC_READY, BUS_OE_N, RD_DATA, BUS_SAMPLE}
                !== {nt.rc, nt.f, ~nt.f, nt.d, nt.b})
            begin
                n_fail++;
                $display("Error at %0t: got %h expected %h", $time,
                    {RESET_CAUSE, FUNC_READY, BUS_OE_N, RD_DATA, BUS_SAMPLE},
                    {nt.rc, nt.f, ~nt.f, nt.d, nt.b});
            end
        end
    end
    // =====
    // boot, then two reset kinds (bus, global with bus), each with and without hold
    initial
    begin
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK);
        boot <= 1'b0;
        repeat (6) @(posedge CLK);
        fn = 1'b1;
        cause = CAUSE_GLOBAL;
        for (int k = 0; k < 4; k++)
        begin
            for (int i = 0; i < 8; i++)
                step(1'b1, i[2:0], 3'(i + 7));
            REG_HOLD_N <= !k[0];
            rst_req <= 1'b1;
            tie <= k[1];
            cause = k[0] ? CAUSE_HELD : (k[1] ? CAUSE_GLOBAL : CAUSE_HOST);
            for (int i = 0; i < 8; i++)
                if (!k[0] && (k[1] || i >= STICKY_COUNT))
                    m[i] = 8'h00;
            fn = 1'b0;
            repeat (4) @(posedge CLK);
            for (int i = 0; i < 3; i++)
                step(1'b1, 3'h0, 3'h0);
            @(posedge CLK);
            rst_req <= 1'b0;
            WR_EN <= 1'b0;
            repeat (5) @(posedge CLK);
            REG_HOLD_N <= 1'b1;
            fn = 1'b1;
            for (int i = 0; i < 8; i++)
                step(1'b0, 3'h0, i[2:0]);
        end
        repeat (4) @(posedge CLK);
        complete_run;
    end
endmodule
